/* File: design/pcips_status_caps.sv */
// Overview of operation
// - Pending bit high while any transaction outstanding
// - Pending clears only when all transactions finished
// - Unsupported request sets its write-one-clear flag
// - Fatal error sets flag regardless of enable
// - Non-fatal error sets flag regardless of enable
// - Correctable error sets flag regardless of enable
// - Mask never suppresses detected flags
// - Only locally detected errors set flags
// - Port number field reads constant 02h
// - L0s exit latency defaults to 100b
// - L0s latency field is write-once
// - ASPM support field reads 11b
// - L1 advertised but not implemented
// - Width x16, or x1 when forced
// - Max link speed reads 1h
// - Unsupported request reported only when enabled
// - Common clock setting alters reported latency
`timescale 1ns/1ps
`default_nettype none

module pcips_status_caps
  import pcips_pkg::*;
#(
  parameter int unsigned NUM_VC = 2,
  parameter int unsigned TXN_CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [CFG_AW-1:0] cfgAddr,
  input wire logic cfgRd,
  input wire logic cfgWr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  output logic cfgRdValid,
  input wire logic [DEV_CTRL_W-1:0] devCtrlReg,
  input wire logic advErrEnable,
  input wire logic corrErrMask,
  input wire logic commonClkCfg,
  input wire logic forceX1Pin,
  input wire logic urDetect,
  input wire logic fatalDetect,
  input wire logic nonFatalDetect,
  input wire logic corrDetect,
  input wire logic [NUM_VC-1:0] txnIssue,
  input wire logic [NUM_VC-1:0] txnRetire,
  output logic txnPending,
  output logic urReport,
  output logic fatalReport,
  output logic nonFatalReport,
  output logic corrReport
);

  localparam pcips_state_t STATE_RESET = '{
    errFlags: DEV_STAT_RESET[ERR_FLAGS-1:0],
    pending: DEV_STAT_RESET[DEV_STAT_PEND_BIT],
    l0sLatency: LINK_CAP_L0S_DEFAULT,
    l0sLocked: 1'b0,
    forceX1Sync: 2'h0,
    report: '0,
    rdData: 32'h00000000,
    rdValid: 1'b0
  };

  logic [1:0] rstPipe_reg;
  logic rstSync_b;
  pcips_state_t state_reg;
  pcips_state_t state_next;
  logic [NUM_VC-1:0] vcBusy;
  logic [ERR_FLAGS-1:0] errSet;
  logic [ERR_FLAGS-1:0] errClr;
  logic [ERR_FLAGS-1:0] errEnable;
  logic [DEV_STAT_W-1:0] devStatValue;
  logic [31:0] linkCapValue;
  logic [2:0] l0sReported;
  logic [5:0] widthReported;
  logic wrDevStat;
  logic wrLinkCapL0s;
  logic [5:0] cfgDword;

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end

  assign rstSync_b = rstPipe_reg[1];

  // One outstanding counter per virtual channel
  genvar vc;
  generate
    for (vc = 0; vc < NUM_VC; vc++) begin : gVc
      pcips_txn_tracker #(
        .CNT_W(TXN_CNT_W)
      ) uTracker (
        .mclk(mclk),
        .rstSync_b(rstSync_b),
        .issue(txnIssue[vc]),
        .retire(txnRetire[vc]),
        .busy(vcBusy[vc])
      );
    end
  endgenerate

  assign cfgDword = cfgAddr[CFG_AW-1:2];

  // Error inputs carry only locally detected errors; received
  // messages never reach this block
  always_comb begin
    errSet = '0;
    errSet[PCIPS_ERR_UR] = urDetect;
    errSet[PCIPS_ERR_FATAL] = fatalDetect;
    errSet[PCIPS_ERR_NONFATAL] = nonFatalDetect;
    errSet[PCIPS_ERR_CORR] = corrDetect;
  end

  always_comb begin
    errEnable = '0;
    errEnable[PCIPS_ERR_UR] = devCtrlReg[DEV_CTRL_UR_EN_BIT];
    errEnable[PCIPS_ERR_FATAL] = devCtrlReg[DEV_CTRL_FATAL_EN_BIT];
    errEnable[PCIPS_ERR_NONFATAL] = devCtrlReg[DEV_CTRL_NONFATAL_EN_BIT];
    // Mask gates the report only, never the logged flag
    errEnable[PCIPS_ERR_CORR] = devCtrlReg[DEV_CTRL_CORR_EN_BIT]
                                && !(advErrEnable && corrErrMask);
  end

  // Read views of both registers
  always_comb begin
    devStatValue = '0;
    devStatValue[DEV_STAT_PEND_BIT] = state_reg.pending;
    devStatValue[DEV_STAT_UR_BIT] = state_reg.errFlags[PCIPS_ERR_UR];
    devStatValue[DEV_STAT_FATAL_BIT] = state_reg.errFlags[PCIPS_ERR_FATAL];
    devStatValue[DEV_STAT_NONFATAL_BIT] = state_reg.errFlags[PCIPS_ERR_NONFATAL];
    devStatValue[DEV_STAT_CORR_BIT] = state_reg.errFlags[PCIPS_ERR_CORR];
  end

  always_comb begin
    // Common clock shortens exit by one step, floor at zero
    if (commonClkCfg && state_reg.l0sLatency != LINK_CAP_L0S_MIN) begin
      l0sReported = state_reg.l0sLatency - LINK_CAP_L0S_STEP;
    end else begin
      l0sReported = state_reg.l0sLatency;
    end
    if (state_reg.forceX1Sync[1]) begin
      widthReported = LINK_CAP_WIDTH_X1;
    end else begin
      widthReported = LINK_CAP_WIDTH_X16;
    end
    linkCapValue = '0;
    linkCapValue[LINK_CAP_PORT_LSB +: 8] = LINK_CAP_PORT_NUM;
    linkCapValue[LINK_CAP_L0S_LSB +: 3] = l0sReported;
    // Advertised only; no L1 entry logic exists in this port
    linkCapValue[LINK_CAP_ASPM_LSB +: 2] = LINK_CAP_ASPM_L0S_L1;
    linkCapValue[LINK_CAP_WIDTH_LSB +: 6] = widthReported;
    linkCapValue[LINK_CAP_SPEED_LSB +: 4] = LINK_CAP_SPEED_2G5;
  end

  // Write decode
  assign wrDevStat = cfgWr && cfgDword == DEV_STAT_DWORD && cfgByteEn[DEV_STAT_LANE];
  assign wrLinkCapL0s = cfgWr && cfgDword == LINK_CAP_DWORD && cfgByteEn[L0S_LANE];

  always_comb begin
    errClr = '0;
    if (wrDevStat) begin
      errClr = cfgWrData[DEV_STAT_SHIFT +: ERR_FLAGS];
    end
  end

  always_comb begin
    state_next = state_reg;

    // Set wins over a same-cycle clear
    state_next.errFlags = (state_reg.errFlags & ~errClr) | errSet;

    // Drops only after every channel has drained
    state_next.pending = |vcBusy;

    // First write with the latency byte lane locks the field
    if (wrLinkCapL0s && !state_reg.l0sLocked) begin
      state_next.l0sLatency = cfgWrData[LINK_CAP_L0S_LSB +: 3];
      state_next.l0sLocked = 1'b1;
    end

    // Strap pin is asynchronous to mclk
    state_next.forceX1Sync = {state_reg.forceX1Sync[0], forceX1Pin};

    state_next.report = errSet & errEnable;

    state_next.rdValid = cfgRd;
    state_next.rdData = '0;
    if (cfgRd) begin
      if (cfgDword == DEV_STAT_DWORD) begin
        state_next.rdData[DEV_STAT_SHIFT +: DEV_STAT_W] = devStatValue;
      end else if (cfgDword == LINK_CAP_DWORD) begin
        state_next.rdData = linkCapValue;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfgRdData = state_reg.rdData;
  assign cfgRdValid = state_reg.rdValid;
  assign txnPending = state_reg.pending;
  assign urReport = state_reg.report[PCIPS_ERR_UR];
  assign fatalReport = state_reg.report[PCIPS_ERR_FATAL];
  assign nonFatalReport = state_reg.report[PCIPS_ERR_NONFATAL];
  assign corrReport = state_reg.report[PCIPS_ERR_CORR];

endmodule : pcips_status_caps

`default_nettype wire

/* File: design/pcips_pkg.sv */
package pcips_pkg;

  // Configuration space addressing
  localparam int unsigned CFG_AW = 8;
  localparam logic [7:0] DEV_STAT_OFFSET = 8'hAA;
  localparam logic [7:0] LINK_CAP_OFFSET = 8'hAC;
  localparam logic [5:0] DEV_STAT_DWORD = DEV_STAT_OFFSET[7:2];
  localparam logic [5:0] LINK_CAP_DWORD = LINK_CAP_OFFSET[7:2];
  localparam logic [1:0] DEV_STAT_LANE = DEV_STAT_OFFSET[1:0];
  localparam int unsigned DEV_STAT_SHIFT = 8 * DEV_STAT_LANE;
  localparam int unsigned L0S_LANE = 1;

  // Device status layout
  localparam int unsigned DEV_STAT_W = 16;
  localparam logic [15:0] DEV_STAT_RESET = 16'h0000;
  localparam int unsigned DEV_STAT_PEND_BIT = 5;
  localparam int unsigned DEV_STAT_UR_BIT = 3;
  localparam int unsigned DEV_STAT_FATAL_BIT = 2;
  localparam int unsigned DEV_STAT_NONFATAL_BIT = 1;
  localparam int unsigned DEV_STAT_CORR_BIT = 0;
  localparam int unsigned ERR_FLAGS = 4;

  // Device control enable positions, register owned elsewhere
  localparam int unsigned DEV_CTRL_W = 16;
  localparam int unsigned DEV_CTRL_UR_EN_BIT = 3;
  localparam int unsigned DEV_CTRL_FATAL_EN_BIT = 2;
  localparam int unsigned DEV_CTRL_NONFATAL_EN_BIT = 1;
  localparam int unsigned DEV_CTRL_CORR_EN_BIT = 0;

  // Link capabilities layout
  localparam logic [31:0] LINK_CAP_RESET = 32'h02014D01;
  localparam int unsigned LINK_CAP_PORT_LSB = 24;
  localparam int unsigned LINK_CAP_L0S_LSB = 12;
  localparam int unsigned LINK_CAP_ASPM_LSB = 10;
  localparam int unsigned LINK_CAP_WIDTH_LSB = 4;
  localparam int unsigned LINK_CAP_SPEED_LSB = 0;
  localparam logic [7:0] LINK_CAP_PORT_NUM = 8'h02;
  localparam logic [2:0] LINK_CAP_L0S_DEFAULT = 3'h4;
  localparam logic [2:0] LINK_CAP_L0S_MIN = 3'h0;
  localparam logic [2:0] LINK_CAP_L0S_STEP = 3'h1;
  localparam logic [1:0] LINK_CAP_ASPM_L0S_L1 = 2'h3;
  localparam logic [5:0] LINK_CAP_WIDTH_X16 = 6'h10;
  localparam logic [5:0] LINK_CAP_WIDTH_X1 = 6'h01;
  localparam logic [3:0] LINK_CAP_SPEED_2G5 = 4'h1;

  // Report pulse order, same as the flag order
  typedef enum logic [1:0] {
    PCIPS_ERR_CORR = 2'h0,
    PCIPS_ERR_NONFATAL = 2'h1,
    PCIPS_ERR_FATAL = 2'h2,
    PCIPS_ERR_UR = 2'h3
  } pcips_err_t;

  typedef struct packed {
    logic [ERR_FLAGS-1:0] errFlags;
    logic pending;
    logic [2:0] l0sLatency;
    logic l0sLocked;
    logic [1:0] forceX1Sync;
    logic [ERR_FLAGS-1:0] report;
    logic [31:0] rdData;
    logic rdValid;
  } pcips_state_t;

  typedef struct packed {
    logic [15:0] count;
  } pcips_trk_state_t;

endpackage : pcips_pkg

/* File: design/pcips_txn_tracker.sv */
`timescale 1ns/1ps
`default_nettype none

module pcips_txn_tracker
  import pcips_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rstSync_b,
  input wire logic issue,
  input wire logic retire,
  output logic busy
);

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // Simultaneous issue and retire leave the count alone
  always_comb begin
    count_next = count_reg;
    if (issue && !retire && count_reg != CNT_MAX) begin
      count_next = count_reg + CNT_ONE;
    end else if (retire && !issue && count_reg != CNT_ZERO) begin
      count_next = count_reg - CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count_reg <= CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  // Saturation at CNT_MAX drops further issues; size CNT_W above the real limit
  assign busy = (count_reg != CNT_ZERO);

endmodule : pcips_txn_tracker

`default_nettype wire

/* File: sim/pcips_status_caps_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pcips_status_caps_properties
  import pcips_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [CFG_AW-1:0] cfgAddr,
  input wire logic cfgRd,
  input wire logic [31:0] cfgRdData,
  input wire logic [DEV_CTRL_W-1:0] devCtrlReg,
  input wire logic advErrEnable,
  input wire logic corrErrMask,
  input wire logic forceX1Pin,
  input wire logic urDetect,
  input wire logic fatalDetect,
  input wire logic nonFatalDetect,
  input wire logic corrDetect,
  input wire logic txnPending,
  input wire logic urReport,
  input wire logic fatalReport,
  input wire logic nonFatalReport,
  input wire logic corrReport
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_linkCapRd; cfgRd && cfgAddr[7:2] == LINK_CAP_DWORD; endsequence
  sequence s_devStatRd; cfgRd && cfgAddr[7:2] == DEV_STAT_DWORD; endsequence
  property p_port; s_linkCapRd |=> cfgRdData[31:24] == 8'h02; endproperty
  a_port: assert property (p_port) else $error("port number");
  property p_aspm; s_linkCapRd |=> cfgRdData[11:10] == 2'h3; endproperty
  a_aspm: assert property (p_aspm) else $error("aspm field");
  property p_speed; s_linkCapRd |=> cfgRdData[3:0] == 4'h1 && cfgRdData[23:15] == 9'h000;
  endproperty
  a_speed: assert property (p_speed) else $error("speed or reserved");
  property p_x1; forceX1Pin [*4] ##0 s_linkCapRd |=> cfgRdData[9:4] == 6'h01; endproperty
  a_x1: assert property (p_x1) else $error("forced width");
  property p_x16; !forceX1Pin [*4] ##0 s_linkCapRd |=> cfgRdData[9:4] == 6'h10; endproperty
  a_x16: assert property (p_x16) else $error("full width");
  property p_devStatResv;
    s_devStatRd |=> cfgRdData[15:0] == 16'h0000 && cfgRdData[31:22] == 10'h000 && !cfgRdData[20];
  endproperty
  a_devStatResv: assert property (p_devStatResv) else $error("status reserved");
  property p_pend; s_devStatRd |=> cfgRdData[21] == $past(txnPending); endproperty
  a_pend: assert property (p_pend) else $error("pending bit");
  property p_fatal; fatalReport |-> $past(fatalDetect && devCtrlReg[2]); endproperty
  a_fatal: assert property (p_fatal) else $error("fatal report");
  property p_nonFatal; nonFatalReport |-> $past(nonFatalDetect && devCtrlReg[1]); endproperty
  a_nonFatal: assert property (p_nonFatal) else $error("nonfatal report");
  property p_ur; urReport |-> $past(urDetect && devCtrlReg[3]); endproperty
  a_ur: assert property (p_ur) else $error("ur report");
  property p_corr;
    corrReport |-> $past(corrDetect && devCtrlReg[0] && !(advErrEnable && corrErrMask));
  endproperty
  a_corr: assert property (p_corr) else $error("corr report");
  property p_urFlag; $past(rst_b, 2) && urDetect ##1 s_devStatRd |=> cfgRdData[19]; endproperty
  a_urFlag: assert property (p_urFlag) else $error("ur flag");
endmodule : pcips_status_caps_properties
bind pcips_status_caps pcips_status_caps_properties pcips_status_caps_properties_inst (.*);
`default_nettype wire

/* File: sim/pcips_status_caps_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pcips_status_caps_tb_top;
  logic mclk = 1'b0, rst_b = 1'b0, cfgRd = 1'b0, cfgWr = 1'b0, cfgRdValid;
  logic advErrEnable = 1'b0, corrErrMask = 1'b0, commonClkCfg = 1'b0, forceX1Pin = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [3:0] cfgByteEn = 4'h0, det = 4'h0;
  wire logic [3:0] rep;
  logic [31:0] cfgWrData = 32'h00000000, cfgRdData, d;
  logic [15:0] devCtrlReg = 16'h0000;
  logic [1:0] txnIssue = 2'h0, txnRetire = 2'h0;
  logic txnPending;
  int fails = 0, compares = 0;
  pcips_status_caps pcips_status_caps_inst (.mclk(mclk), .rst_b(rst_b), .cfgAddr(cfgAddr),
    .cfgRd(cfgRd), .cfgWr(cfgWr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .devCtrlReg(devCtrlReg),
    .advErrEnable(advErrEnable), .corrErrMask(corrErrMask), .commonClkCfg(commonClkCfg),
    .forceX1Pin(forceX1Pin), .urDetect(det[3]), .fatalDetect(det[2]),
    .nonFatalDetect(det[1]), .corrDetect(det[0]), .txnIssue(txnIssue),
    .txnRetire(txnRetire), .txnPending(txnPending), .urReport(rep[3]),
    .fatalReport(rep[2]), .nonFatalReport(rep[1]), .corrReport(rep[0]));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task step();
    @(posedge mclk);
    #1;
  endtask : step
  task rd(input logic [7:0] a, output logic [31:0] q);
    cfgAddr = a;
    cfgRd = 1'b1;
    step();
    cfgRd = 1'b0;
    q = cfgRdData;
    `CHK("read strobe", 1'b1, cfgRdValid)
    step();
    `CHK("read strobe low", 1'b0, cfgRdValid)
    `CHK("read data idle", 32'h00000000, cfgRdData)
  endtask : rd
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = v;
    cfgWr = 1'b1;
    step();
    cfgWr = 1'b0;
    step();
  endtask : wr
  task t_reset();
    rd(8'hAC, d);
    `CHK("caps reset", 32'h02004D01, d)
    rd(8'hA8, d);
    `CHK("status reset", 32'h00000000, d)
    rd(8'h40, d);
    `CHK("unmapped", 32'h00000000, d)
  endtask : t_reset
  // Each kind alone, enable off then on, so a crossed enable shows up
  task t_errors();
    for (int k = 0; k < 4; k++) begin
      for (int en = 0; en < 2; en++) begin
        devCtrlReg = 16'(en << k);
        det = 4'(1 << k);
        step();
        det = 4'h0;
        `CHK("report", 4'(en << k), rep)
        rd(8'hA8, d);
        `CHK("flag set", 1'b1, d[16+k])
        wr(8'hA8, 4'h4, 32'h00000000);
        rd(8'hAA, d);
        `CHK("flag kept", 1'b1, d[16+k])
        wr(8'hA8, 4'h4, 32'(1 << (16 + k)));
        rd(8'hA8, d);
        `CHK("flag cleared", 32'h00000000, d)
      end
    end
    advErrEnable = 1'b1;
    corrErrMask = 1'b1;
    devCtrlReg = 16'h000F;
    det = 4'h1;
    step();
    det = 4'h0;
    `CHK("masked report", 4'h0, rep)
    rd(8'hA8, d);
    `CHK("masked flag", 32'h00010000, d)
    wr(8'hA8, 4'h4, 32'h000F0000);
  endtask : t_errors
  task t_pending();
    txnIssue = 2'h3;
    step();
    txnIssue = 2'h0;
    step();
    `CHK("pending", 1'b1, txnPending)
    rd(8'hA8, d);
    `CHK("pending bit", 32'h00200000, d)
    txnRetire = 2'h1;
    step();
    txnRetire = 2'h0;
    step();
    `CHK("other vc busy", 1'b1, txnPending)
    txnRetire = 2'h2;
    step();
    txnRetire = 2'h0;
    step();
    `CHK("all done", 1'b0, txnPending)
  endtask : t_pending
  task t_caps();
    commonClkCfg = 1'b1;
    rd(8'hAC, d);
    `CHK("common clock", 32'h02003D01, d)
    commonClkCfg = 1'b0;
    wr(8'hAC, 4'hF, 32'hFFFFAFFF);
    rd(8'hAC, d);
    `CHK("latency once", 32'h02002D01, d)
    wr(8'hAC, 4'hF, 32'h00005000);
    forceX1Pin = 1'b1;
    repeat (4) step();
    rd(8'hAC, d);
    `CHK("locked and x1", 32'h02002C11, d)
  endtask : t_caps
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (4) step();
    t_reset();
    t_errors();
    t_pending();
    t_caps();
    report_and_stop();
  end
endmodule : pcips_status_caps_tb_top
`default_nettype wire
